// ---- verilog/dstc_timing.v ----
`timescale 1ns/10ps
`include "dstc_map.vh"

// Behaviour
// - line sync output is low for the programmed 7-bit sync width in dots.
// - each line repeats after the 11-bit line period in dots.
// - frame sync pulse begins at the line given by frame sync start.
// - frame counts lines up to the frame line total, then restarts.
// - TV sync mode, no external frame sync rise in frame sets missing flag.
// - display off drives the fixed programmable 6-bit red, green, blue colour.
// - off red in bits 7:2; off green 15:10 and blue 7:2 of second register.
// - while timing runs, match pin is 1 exactly when the outgoing pixel equals all match fields.
// - red compares bits 17:12, green 11:6, blue 5:0 of the pixel.
// - outside display interval while timing runs the pixel is zero, so zero match asserts.
// - timing, off-colour and match fields are not touched by reset.
// - vertical display interval ends at the frame display end line.
module dstc_timing #(
	parameter DOT_DIV = 1
) (
	input  wire        clk_i,
	input  wire        resetn_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	input  wire [17:0] pixel_in_i,
	input  wire        ext_line_sync_in_i,
	input  wire        ext_frame_sync_in_i,
	output wire [17:0] pixel_out_bus_o,
	output wire        color_match_out_o,
	output wire        line_sync_n_o,
	output wire        frame_sync_n_o,
	output wire        display_active_o,
	output wire        irq_o
);

	// ****************************************
	// configuration storage
	// ****************************************
	// no reset on the field and colour registers; mode, status and mask are reset
	reg [`DSTC_FRM_MSB:0] frame_display_end_field_reg;
	reg [`DSTC_LSW_MSB:0] line_sync_width_field_reg;
	reg [`DSTC_LP_MSB:0]  line_period_field_reg;
	reg [`DSTC_FRM_MSB:0] frame_sync_start_field_reg;
	reg [`DSTC_FRM_MSB:0] frame_line_total_field_reg;
	reg [5:0]             off_red_reg;
	reg [5:0]             off_green_reg;
	reg [5:0]             off_blue_reg;
	reg [5:0]             match_red_reg;
	reg [5:0]             match_green_reg;
	reg [5:0]             match_blue_reg;
	reg [`DSTC_MODE_W-1:0] mode_reg;
	reg [`DSTC_ST_W-1:0]   status_reg;
	reg [`DSTC_ST_W-1:0]   mask_reg;

	wire [9:0]  word_idx;
	wire        addr_ok;
	wire        wr_en;
	reg         hit;
	reg  [15:0] rd_word;

	assign word_idx  = paddr_i[11:2];
	assign addr_ok   = (paddr_i[1:0] == 2'h0) && (word_idx[9:8] == 2'h0);
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~hit;
	assign wr_en     = psel_i & penable_i & pwrite_i & hit;
	assign prdata_o  = {16'h0000, rd_word};

	// ****************************************
	// apb decode and read mux
	// ****************************************
	// reserved bits read as zero; software must not rely on that
	always @* begin
		hit     = addr_ok;
		rd_word = 16'h0000;
		case (word_idx[7:0])
		`DSTC_IDX_FRAME_DISP_END: begin
			rd_word[`DSTC_FRM_MSB:0] = frame_display_end_field_reg;
		end
		`DSTC_IDX_LINE_SYNC_WIDTH: begin
			rd_word[`DSTC_LSW_MSB:0] = line_sync_width_field_reg;
		end
		`DSTC_IDX_LINE_PERIOD: begin
			rd_word[`DSTC_LP_MSB:0] = line_period_field_reg;
		end
		`DSTC_IDX_FRAME_SYNC_START: begin
			rd_word[`DSTC_FRM_MSB:0] = frame_sync_start_field_reg;
		end
		`DSTC_IDX_FRAME_LINE_TOTAL: begin
			rd_word[`DSTC_FRM_MSB:0] = frame_line_total_field_reg;
		end
		`DSTC_IDX_OFF_RED: begin
			rd_word[`DSTC_RED_MSB:`DSTC_RED_LSB] = off_red_reg;
		end
		`DSTC_IDX_OFF_GB: begin
			rd_word[`DSTC_GRN_MSB:`DSTC_GRN_LSB] = off_green_reg;
			rd_word[`DSTC_BLU_MSB:`DSTC_BLU_LSB] = off_blue_reg;
		end
		`DSTC_IDX_MATCH_RED: begin
			rd_word[`DSTC_RED_MSB:`DSTC_RED_LSB] = match_red_reg;
		end
		`DSTC_IDX_MATCH_GB: begin
			rd_word[`DSTC_GRN_MSB:`DSTC_GRN_LSB] = match_green_reg;
			rd_word[`DSTC_BLU_MSB:`DSTC_BLU_LSB] = match_blue_reg;
		end
		`DSTC_IDX_MODE: begin
			rd_word[`DSTC_MODE_W-1:0] = mode_reg;
		end
		`DSTC_IDX_STATUS: begin
			rd_word[`DSTC_ST_W-1:0] = status_reg;
		end
		`DSTC_IDX_MASK: begin
			rd_word[`DSTC_ST_W-1:0] = mask_reg;
		end
		default: begin
			hit = 1'b0;
		end
		endcase
	end

	// ****************************************
	// register writes
	// ****************************************
	always @(posedge clk_i) begin
		if (wr_en) begin
			case (word_idx[7:0])
			`DSTC_IDX_FRAME_DISP_END: begin
				frame_display_end_field_reg <= pwdata_i[`DSTC_FRM_MSB:0];
			end
			`DSTC_IDX_LINE_SYNC_WIDTH: begin
				line_sync_width_field_reg <= pwdata_i[`DSTC_LSW_MSB:0];
			end
			`DSTC_IDX_LINE_PERIOD: begin
				line_period_field_reg <= pwdata_i[`DSTC_LP_MSB:0];
			end
			`DSTC_IDX_FRAME_SYNC_START: begin
				frame_sync_start_field_reg <= pwdata_i[`DSTC_FRM_MSB:0];
			end
			`DSTC_IDX_FRAME_LINE_TOTAL: begin
				frame_line_total_field_reg <= pwdata_i[`DSTC_FRM_MSB:0];
			end
			`DSTC_IDX_OFF_RED: begin
				off_red_reg <= pwdata_i[`DSTC_RED_MSB:`DSTC_RED_LSB];
			end
			`DSTC_IDX_OFF_GB: begin
				off_green_reg <= pwdata_i[`DSTC_GRN_MSB:`DSTC_GRN_LSB];
				off_blue_reg  <= pwdata_i[`DSTC_BLU_MSB:`DSTC_BLU_LSB];
			end
			`DSTC_IDX_MATCH_RED: begin
				match_red_reg <= pwdata_i[`DSTC_RED_MSB:`DSTC_RED_LSB];
			end
			`DSTC_IDX_MATCH_GB: begin
				match_green_reg <= pwdata_i[`DSTC_GRN_MSB:`DSTC_GRN_LSB];
				match_blue_reg  <= pwdata_i[`DSTC_BLU_MSB:`DSTC_BLU_LSB];
			end
			default: begin
			end
			endcase
		end
	end

	wire wr_mode   = wr_en && (word_idx[7:0] == `DSTC_IDX_MODE);
	wire wr_status = wr_en && (word_idx[7:0] == `DSTC_IDX_STATUS);
	wire wr_mask   = wr_en && (word_idx[7:0] == `DSTC_IDX_MASK);

	// ****************************************
	// dot enable divider
	// ****************************************
	reg  [7:0] div_cnt_reg;
	wire       dot_en;

	assign dot_en = (div_cnt_reg == (DOT_DIV[7:0] - 8'h01));

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_cnt_reg <= 8'h00;
		end else if (dot_en) begin
			div_cnt_reg <= 8'h00;
		end else begin
			div_cnt_reg <= div_cnt_reg + 8'h01;
		end
	end

	// ****************************************
	// raster counters
	// ****************************************
	reg  [10:0] h_cnt_reg;
	reg  [9:0]  v_cnt_reg;
	reg         ext_line_dly_reg;
	reg         ext_frame_dly_reg;
	reg         ext_rise_seen_reg;
	wire        run;
	wire        tv_mode;
	wire        ext_line_fall;
	wire        ext_frame_rise;
	wire        line_wrap;
	wire        frame_wrap;

	assign run      = mode_reg[`DSTC_MODE_TIMING_EN];
	assign tv_mode  = ({mode_reg[`DSTC_MODE_TV_HI], mode_reg[`DSTC_MODE_TV_LO]}
			== `DSTC_TV_SYNC_MODE);
	assign ext_line_fall  = ext_line_dly_reg & ~ext_line_sync_in_i;
	assign ext_frame_rise = ~ext_frame_dly_reg & ext_frame_sync_in_i;
	// period of N dots: count 0..N-1
	assign line_wrap  = (h_cnt_reg >= line_period_field_reg - 11'h001) ||
			(tv_mode && ext_line_fall);
	// frame of N lines, retrace included
	assign frame_wrap = line_wrap &&
			(v_cnt_reg >= frame_line_total_field_reg - 10'h001);

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ext_line_dly_reg  <= 1'b1;
			ext_frame_dly_reg <= 1'b1;
		end else if (dot_en) begin
			ext_line_dly_reg  <= ext_line_sync_in_i;
			ext_frame_dly_reg <= ext_frame_sync_in_i;
		end
	end

	// TV sync mode only: external line sync fall restarts the line; external frame rise on a line wrap ends frame
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			h_cnt_reg <= 11'h000;
			v_cnt_reg <= 10'h000;
		end else if (!run) begin
			h_cnt_reg <= 11'h000;
			v_cnt_reg <= 10'h000;
		end else if (dot_en) begin
			if (line_wrap) begin
				h_cnt_reg <= 11'h000;
				if (frame_wrap || (tv_mode && ext_frame_rise)) begin
					v_cnt_reg <= 10'h000;
				end else begin
					v_cnt_reg <= v_cnt_reg + 10'h001;
				end
			end else begin
				h_cnt_reg <= h_cnt_reg + 11'h001;
			end
		end
	end

	// ****************************************
	// external frame sync supervision
	// ****************************************
	wire missing_evt;

	assign missing_evt = run && dot_en && tv_mode && frame_wrap &&
			!ext_rise_seen_reg && !ext_frame_rise;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ext_rise_seen_reg <= 1'b0;
		end else if (!run || !tv_mode) begin
			ext_rise_seen_reg <= 1'b0;
		end else if (dot_en) begin
			if (frame_wrap) begin
				ext_rise_seen_reg <= 1'b0;
			end else if (ext_frame_rise) begin
				ext_rise_seen_reg <= 1'b1;
			end
		end
	end

	// ****************************************
	// sync, display interval and pixel path
	// ****************************************
	reg         line_sync_n_reg;
	reg         frame_sync_n_reg;
	reg         active_reg;
	reg  [17:0] pixel_reg;
	reg         match_reg;
	wire        active_now;
	wire [17:0] pixel_next;
	wire [17:0] match_word;

	// active after the line sync pulse, above the frame display end line
	assign active_now = run &&
			(h_cnt_reg >= {4'h0, line_sync_width_field_reg}) &&
			(v_cnt_reg < frame_display_end_field_reg);
	assign pixel_next = !active_now ? 18'h00000 :
			mode_reg[`DSTC_MODE_DISP_ON] ? pixel_in_i :
			{off_red_reg, off_green_reg, off_blue_reg};
	assign match_word = {match_red_reg, match_green_reg, match_blue_reg};

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			line_sync_n_reg  <= 1'b1;
			frame_sync_n_reg <= 1'b1;
			active_reg       <= 1'b0;
			pixel_reg        <= 18'h00000;
			match_reg        <= 1'b0;
		end else if (!run) begin
			line_sync_n_reg  <= 1'b1;
			frame_sync_n_reg <= 1'b1;
			active_reg       <= 1'b0;
			pixel_reg        <= 18'h00000;
			match_reg        <= 1'b0;
		end else if (dot_en) begin
			line_sync_n_reg  <= !(h_cnt_reg <
					{4'h0, line_sync_width_field_reg});
			frame_sync_n_reg <= !(v_cnt_reg >=
					frame_sync_start_field_reg);
			active_reg       <= active_now;
			pixel_reg        <= pixel_next;
			// bit slices 17:12, 11:6, 5:0 line up with red, green, blue
			match_reg        <= (pixel_next == match_word);
		end
	end

	assign line_sync_n_o     = line_sync_n_reg;
	assign frame_sync_n_o    = frame_sync_n_reg;
	assign display_active_o  = active_reg;
	assign pixel_out_bus_o   = pixel_reg;
	assign color_match_out_o = match_reg;

	// ****************************************
	// mode, status and interrupt
	// ****************************************
	wire [`DSTC_ST_W-1:0] evt;

	assign evt = {(run && dot_en && frame_wrap), missing_evt};

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_reg   <= `DSTC_MODE_RST;
			status_reg <= `DSTC_ST_RST;
			mask_reg   <= `DSTC_ST_RST;
		end else begin
			if (wr_mode) begin
				mode_reg <= pwdata_i[`DSTC_MODE_W-1:0];
			end
			if (wr_mask) begin
				mask_reg <= pwdata_i[`DSTC_ST_W-1:0];
			end
			// a new event wins over a write-one clear in the same cycle
			status_reg <= (status_reg &
					~(wr_status ? pwdata_i[`DSTC_ST_W-1:0] : 2'h0)) | evt;
		end
	end

	assign irq_o = |(status_reg & mask_reg);

endmodule // dstc_timing

// ---- verilog/dstc_map.vh ----
`ifndef DSTC_MAP_VH
`define DSTC_MAP_VH
// word indices; byte address is four times the index
`define DSTC_IDX_FRAME_DISP_END   8'h2c
`define DSTC_IDX_LINE_SYNC_WIDTH  8'h2e
`define DSTC_IDX_LINE_PERIOD      8'h30
`define DSTC_IDX_FRAME_SYNC_START 8'h32
`define DSTC_IDX_FRAME_LINE_TOTAL 8'h34
`define DSTC_IDX_OFF_RED          8'h36
`define DSTC_IDX_OFF_GB           8'h38
`define DSTC_IDX_MATCH_RED        8'h3a
`define DSTC_IDX_MATCH_GB         8'h3c
`define DSTC_IDX_MODE             8'h40
`define DSTC_IDX_STATUS           8'h41
`define DSTC_IDX_MASK             8'h42
// field layout
`define DSTC_LSW_MSB     6
`define DSTC_LP_MSB      10
`define DSTC_FRM_MSB     9
`define DSTC_RED_MSB     7
`define DSTC_RED_LSB     2
`define DSTC_GRN_MSB     15
`define DSTC_GRN_LSB     10
`define DSTC_BLU_MSB     7
`define DSTC_BLU_LSB     2
// mode register bits
`define DSTC_MODE_TIMING_EN 0
`define DSTC_MODE_DISP_ON   1
`define DSTC_MODE_TV_LO     2
`define DSTC_MODE_TV_HI     3
`define DSTC_MODE_W         4
`define DSTC_MODE_RST       4'h0
`define DSTC_TV_SYNC_MODE   2'b10
// status / mask bits
`define DSTC_ST_EXT_MISSING 0
`define DSTC_ST_FRAME_END   1
`define DSTC_ST_W           2
`define DSTC_ST_RST         2'h0
`endif

// ---- testbench/dstc_sync_src.sv ----
`timescale 1ns/10ps
// ***
// free-running outer sync source
// ***
module dstc_sync_src #(
	parameter int LINE  = 20,
	parameter int LINES = 6
) (
	input  logic clk_i,
	input  logic frame_on_i,
	output logic line_n_o = 1'h1,
	output logic frame_n_o = 1'h1
);
	int h = 0;
	int v = 0;
	always @(posedge clk_i) begin
		h <= (h == LINE - 1) ? 0 : h + 1;
		if (h == LINE - 1)
			v <= (v == LINES - 1) ? 0 : v + 1;
		line_n_o <= !(h < 2);
		// pulse on line 0: falls after and rises before ours
		frame_n_o <= !(frame_on_i && v == 0);
	end
endmodule // dstc_sync_src

// ---- testbench/dstc_timing_monitor.sv ----
`timescale 1ns/10ps
// ***
// checker
// ***
module dstc_timing_monitor #(
	parameter DOT_DIV = 1
) (
	input logic        clk_i,
	input logic        resetn_i,
	input logic        psel_i,
	input logic        penable_i,
	input logic        pwrite_i,
	input logic [11:0] paddr_i,
	input logic [31:0] pwdata_i,
	input logic        pready_o,
	input logic [17:0] pixel_out_bus_o,
	input logic        color_match_out_o,
	input logic        line_sync_n_o,
	input logic        frame_sync_n_o,
	input logic        display_active_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	logic [31:0] lsw_reg, lp_reg, mr_reg, mgb_reg, or_reg, ogb_reg;
	logic [3:0]  mode_reg;
	logic [11:0] low_reg, per_reg;
	logic        seen_reg;
	wire         wr = psel_i & penable_i & pwrite_i & pready_o;
	wire  [17:0] mt = {mr_reg[7:2], mgb_reg[15:10], mgb_reg[7:2]};
	wire         tv = mode_reg[3:2] == 2'h2;
	// field copies keep no reset, like the block's own
	always @(posedge clk_i)
		if (wr)
			case (paddr_i)
			12'h0b8: lsw_reg <= pwdata_i;
			12'h0c0: lp_reg <= pwdata_i;
			12'h0d8: or_reg <= pwdata_i;
			12'h0e0: ogb_reg <= pwdata_i;
			12'he8: mr_reg <= pwdata_i;
			12'h0f0: mgb_reg <= pwdata_i;
			default: ;
			endcase
	always @(posedge clk_i or negedge resetn_i)
		if (!resetn_i) begin
			mode_reg <= 4'h0;
			low_reg <= 12'h0;
			per_reg <= 12'h0;
			seen_reg <= 1'h0;
		end else begin
			if (wr && paddr_i == 12'h100)
				mode_reg <= pwdata_i[3:0];
			low_reg <= line_sync_n_o ? 12'h0 : low_reg + 12'h1;
			per_reg <= $fell(line_sync_n_o) ? 12'h1 : per_reg + 12'h1;
			// a mode write may cut a line short
			seen_reg <= (wr && paddr_i == 12'h100) ? 1'h0
				: ($fell(line_sync_n_o) ? 1'h1 : seen_reg);
		end
	property p_lsw;
		$rose(line_sync_n_o) && seen_reg && !tv
			|-> low_reg == {5'h0, lsw_reg[6:0]};
	endproperty
	a_lsw: assert property (p_lsw) else $error("sync width");
	property p_per;
		$fell(line_sync_n_o) && seen_reg && !tv
			|-> per_reg == {1'h0, lp_reg[10:0]};
	endproperty
	a_per: assert property (p_per) else $error("line period");
	property p_match;
		mode_reg[0] && $past(mode_reg[0])
			|-> color_match_out_o == (pixel_out_bus_o == $past(mt));
	endproperty
	a_match: assert property (p_match) else $error("match");
	property p_blank;
		!display_active_o |-> pixel_out_bus_o == 18'h0;
	endproperty
	a_blank: assert property (p_blank) else $error("blank pixel");
	property p_off;
		display_active_o && !$past(mode_reg[1]) |-> pixel_out_bus_o
			== {or_reg[7:2], ogb_reg[15:10], ogb_reg[7:2]};
	endproperty
	a_off: assert property (p_off) else $error("off colour");
	property p_act;
		$rose(display_active_o) |-> $rose(line_sync_n_o);
	endproperty
	a_act: assert property (p_act) else $error("active start");
	property p_fs;
		$fell(frame_sync_n_o) |-> $fell(line_sync_n_o);
	endproperty
	a_fs: assert property (p_fs) else $error("frame sync start");
	property p_fr;
		mode_reg[0] && $rose(frame_sync_n_o) |-> $fell(line_sync_n_o);
	endproperty
	a_fr: assert property (p_fr) else $error("frame wrap");
	c_match: cover property ($rose(color_match_out_o));
	c_frame: cover property ($rose(frame_sync_n_o));
	c_act: cover property ($rose(display_active_o));
endmodule // dstc_timing_monitor
bind dstc_timing dstc_timing_monitor #(.DOT_DIV(DOT_DIV)) u_mon (
	.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pready_o(pready_o),
	.pixel_out_bus_o(pixel_out_bus_o),
	.color_match_out_o(color_match_out_o), .line_sync_n_o(line_sync_n_o),
	.frame_sync_n_o(frame_sync_n_o), .display_active_o(display_active_o));

// ---- testbench/dstc_timing_test.sv ----
`timescale 1ns/10ps
// ***
// testbench
// ***
module dstc_timing_test;
	logic        clk_i = 1'h0, resetn_i = 1'h0, psel_i = 1'h0;
	logic        penable_i = 1'h0, pwrite_i = 1'h0, fon = 1'h0;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic [17:0] pixel_in_i = 18'h0, pixel_out_bus_o;
	logic        pready_o, pslverr_o, color_match_out_o, line_sync_n_o;
	logic        frame_sync_n_o, display_active_o, irq_o, xl, xf, er;
	int          mismatches = 0, tests_run = 0, n, a;
	localparam logic [17:0] OFF = {6'h2a, 6'h15, 6'h33};
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) pixel_in_i <= pixel_in_i + 18'h00405;
	dstc_sync_src SRC (.clk_i(clk_i), .frame_on_i(fon), .line_n_o(xl),
		.frame_n_o(xf));
	dstc_timing #(.DOT_DIV(1)) DUT (.clk_i(clk_i), .resetn_i(resetn_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .pixel_in_i(pixel_in_i),
		.ext_line_sync_in_i(xl), .ext_frame_sync_in_i(xf),
		.pixel_out_bus_o(pixel_out_bus_o), .color_match_out_o(color_match_out_o),
		.line_sync_n_o(line_sync_n_o), .frame_sync_n_o(frame_sync_n_o),
		.display_active_o(display_active_o), .irq_o(irq_o));
	task summarize;
		$display("mismatches %0d checks %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	task apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= ad;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'h1 && n < 50);
		if (n == 50) begin
			chk("pready", 1, 0);
			summarize;
		end
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask
	task wcol(input logic [11:0] ad, input logic [17:0] c);
		apb(ad, 1'h1, {24'h0, c[17:12], 2'h0});
		apb(ad + 12'h8, 1'h1, {16'h0, c[11:6], 2'h0, c[5:0], 2'h0});
	endtask
	// waits for sync 0, frame 1 or active 2 to reach level v
	task wt(input int s, input logic v);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((s == 0 ? line_sync_n_o : s == 1 ? frame_sync_n_o
			: display_active_o) !== v && n < 2000);
		if (n == 2000) begin
			chk("wait", 1, 0);
			summarize;
		end
	endtask
	task t_regs;
		logic [11:0] ra [7];
		logic [31:0] rv [7];
		ra = '{12'h0b0, 12'h0b8, 12'h0c0, 12'h0c8, 12'h0d0, 12'h0d8, 12'h0e0};
		rv = '{32'h3, 32'h3, 32'h14, 32'h4, 32'h6, 32'ha8, 32'h54cc};
		for (int i = 0; i < 5; i++)
			apb(ra[i], 1'h1, rv[i]);
		wcol(12'h0d8, OFF);
		wcol(12'h0e8, 18'h0);
		resetn_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'h1;
		for (int i = 0; i < 7; i++) begin
			apb(ra[i], 1'h0, 32'h0);
			chk("reg", rv[i], rd);
		end
		apb(12'h004, 1'h0, 32'h0);
		chk("unmapped err", 1, er);
		apb(12'h0b9, 1'h1, 32'h0);
		chk("misaligned err", 1, er);
	endtask
	task t_sync;
		apb(12'h100, 1'h1, 32'h1);
		wt(0, 0);
		wt(0, 1);
		a = n;
		wt(0, 0);
		chk("sync width", 3, a);
		chk("line period", 20, a + n);
		wt(1, 0);
		wt(1, 1);
		a = n;
		wt(1, 0);
		chk("frame sync low", 40, a);
		chk("frame period", 120, a + n);
		wt(1, 1);
		a = 0;
		repeat (120) begin
			@(posedge clk_i);
			a += int'(display_active_o);
		end
		chk("active dots", 51, a);
	endtask
	task t_pix;
		logic [17:0] mt [4];
		mt = '{OFF, {6'h15, 6'h15, 6'h33}, {6'h2a, 6'h33, 6'h33},
			{6'h2a, 6'h15, 6'h2a}};
		wt(2, 1);
		chk("off pixel", OFF, pixel_out_bus_o);
		chk("active match", 0, color_match_out_o);
		wt(2, 0);
		chk("blank match", 1, color_match_out_o);
		for (int k = 0; k < 4; k++) begin
			wcol(12'h0e8, mt[k]);
			wt(2, 0);
			wt(2, 1);
			chk("match", k == 0, color_match_out_o);
		end
		// display on: the pixel follows the input one dot later
		apb(12'h100, 1'h1, 32'h3);
		wt(2, 0);
		wt(2, 1);
		chk("on pixel", {14'h0, pixel_in_i - 18'h00405},
			pixel_out_bus_o);
	endtask
	task t_tv;
		apb(12'h100, 1'h1, 32'h9);
		repeat (300) @(posedge clk_i);
		apb(12'h104, 1'h0, 32'h0);
		chk("missing flag", 1, rd[0]);
		chk("frame end flag", 1, rd[1]);
		chk("irq masked", 0, irq_o);
		apb(12'h108, 1'h1, 32'h1);
		@(posedge clk_i);
		chk("irq", 1, irq_o);
		fon <= 1'h1;
		repeat (300) @(posedge clk_i);
		apb(12'h104, 1'h1, 32'h1);
		repeat (300) @(posedge clk_i);
		apb(12'h104, 1'h0, 32'h0);
		chk("flag stays clear", 0, rd[0]);
		@(posedge clk_i);
		chk("irq clear", 0, irq_o);
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'h1;
		t_regs;
		t_sync;
		t_pix;
		t_tv;
		summarize;
	end
endmodule // dstc_timing_test
